// ===== pkg/ddr2_cmd_pkg.sv
// Shared types and timing constants for the DDR2 bank command tracker
package ddr2_cmd_pkg;
    // Core clock period in picoseconds (125 MHz)
    localparam int CLK_PERIOD_PS = 8000;
    // Bank count and address width
    localparam int NUM_BANKS = 4;
    localparam int BANK_W    = 2;
    // Width of every down-counter
    localparam int CNT_W     = 8;
    // Delays as times in nanoseconds
    localparam int TRCD_NS   = 15;
    localparam int TRP_NS    = 15;
    localparam int TRFC_NS   = 105;
    localparam int TXSNR_NS  = 115;
    // Mode register delay is counted in clocks
    localparam int TMRD_CK   = 2;
    // Burst length in data beats
    localparam int BURST_LEN = 4;
    // Least times round up to whole cycles
    localparam int TRCD_CYC  = (TRCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TRP_CYC   = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TRFC_CYC  = (TRFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TXSNR_CYC = (TXSNR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TMRD_CYC  = TMRD_CK;
    // Two beats per clock
    localparam int BURST_CYC = BURST_LEN / 2;

    // Per-bank state
    typedef enum logic [2:0] {
        BANK_IDLE       = 3'h0,
        BANK_ACTIVATING = 3'h1,
        BANK_ROW_ACTIVE = 3'h2,
        BANK_READING    = 3'h3,
        BANK_WRITING    = 3'h4,
        BANK_READ_AP    = 3'h5,
        BANK_WRITE_AP   = 3'h6,
        BANK_PRECHARGE  = 3'h7
    } bank_state_t;

    // Device-wide state
    typedef enum logic [1:0] {
        DEV_NORMAL  = 2'h0,
        DEV_REFRESH = 2'h1,
        DEV_MODE    = 2'h2,
        DEV_PALL    = 2'h3
    } dev_state_t;

    // Decoded command
    typedef enum logic [3:0] {
        CMD_DESEL = 4'h0,
        CMD_NOP   = 4'h1,
        CMD_ACT   = 4'h2,
        CMD_RD    = 4'h3,
        CMD_WR    = 4'h4,
        CMD_PRE   = 4'h5,
        CMD_PALL  = 4'h6,
        CMD_REF   = 4'h7,
        CMD_MRS   = 4'h8
    } cmd_t;
endpackage

// ===== hw/bank_state_tracker.sv
// One bank's state machine with its delay down-counter
`timescale 1ns/1ps
`default_nettype none
module bank_state_tracker #(
    parameter int TRCD_CYC  = ddr2_cmd_pkg::TRCD_CYC,
    parameter int TRP_CYC   = ddr2_cmd_pkg::TRP_CYC,
    parameter int BURST_CYC = ddr2_cmd_pkg::BURST_CYC,
    parameter int CNT_W     = ddr2_cmd_pkg::CNT_W
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      go_act,
    input  wire logic                      go_rd,
    input  wire logic                      go_wr,
    input  wire logic                      go_pre,
    input  wire logic                      auto_pre,
    output ddr2_cmd_pkg::bank_state_t      state
);
    logic [CNT_W-1:0]          cnt;        // Cycles left in state
    logic [CNT_W-1:0]          next_cnt;
    ddr2_cmd_pkg::bank_state_t next_state;

    // Next state; strobes arrive only for legal commands
    always_comb
    begin
        next_state = state;
        next_cnt   = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
        if (go_pre)
        begin
            // Closes the row, single or all banks
            next_state = ddr2_cmd_pkg::BANK_PRECHARGE;
            next_cnt   = CNT_W'(TRP_CYC - 1);
        end
        else if (go_act)
        begin
            // Row opens, column access waits out tRCD
            next_state = ddr2_cmd_pkg::BANK_ACTIVATING;
            next_cnt   = CNT_W'(TRCD_CYC - 1);
        end
        else if (go_rd || go_wr)
        begin
            // New burst restarts timing, also mid-burst
            if (auto_pre)
            begin
                // Burst then precharge keeps bank busy
                next_state = go_rd ? ddr2_cmd_pkg::BANK_READ_AP : ddr2_cmd_pkg::BANK_WRITE_AP;
                next_cnt   = CNT_W'(BURST_CYC + TRP_CYC - 1);
            end
            else
            begin
                // Plain burst
                next_state = go_rd ? ddr2_cmd_pkg::BANK_READING : ddr2_cmd_pkg::BANK_WRITING;
                next_cnt   = CNT_W'(BURST_CYC - 1);
            end
        end
        else if (cnt == '0)
        begin
            // Counter expiry ends each transient state
            unique case (state)
                ddr2_cmd_pkg::BANK_ACTIVATING,
                ddr2_cmd_pkg::BANK_READING,
                ddr2_cmd_pkg::BANK_WRITING:
                    next_state = ddr2_cmd_pkg::BANK_ROW_ACTIVE;
                ddr2_cmd_pkg::BANK_READ_AP,
                ddr2_cmd_pkg::BANK_WRITE_AP,
                ddr2_cmd_pkg::BANK_PRECHARGE:
                    next_state = ddr2_cmd_pkg::BANK_IDLE;
                ddr2_cmd_pkg::BANK_IDLE,
                ddr2_cmd_pkg::BANK_ROW_ACTIVE:
                    next_state = state;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ddr2_cmd_pkg::BANK_IDLE;
            cnt   <= '0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_act_opens: assert property (go_act && !go_pre |=> state == ddr2_cmd_pkg::BANK_ACTIVATING)
        else $error("activate did not open row");
    chk_rcd_end: assert property (state == ddr2_cmd_pkg::BANK_ACTIVATING && cnt == '0
        && !go_pre |=> state == ddr2_cmd_pkg::BANK_ROW_ACTIVE)
        else $error("row active not reached after tRCD");
    chk_pre_idle: assert property (go_pre |=> state == ddr2_cmd_pkg::BANK_PRECHARGE
        ##(TRP_CYC) state == ddr2_cmd_pkg::BANK_IDLE || $past(go_pre || go_act))
        else $error("precharge did not end in idle");
    chk_rd_burst: assert property (go_rd && !auto_pre && !go_pre && !go_act
        |=> state == ddr2_cmd_pkg::BANK_READING)
        else $error("read burst state missing");
    chk_wr_burst: assert property (go_wr && !auto_pre && !go_pre && !go_act
        |=> state == ddr2_cmd_pkg::BANK_WRITING)
        else $error("write burst state missing");
    chk_ap_idle: assert property ((state == ddr2_cmd_pkg::BANK_READ_AP
        || state == ddr2_cmd_pkg::BANK_WRITE_AP) && cnt == '0 && !go_pre
        |=> state == ddr2_cmd_pkg::BANK_IDLE)
        else $error("auto precharge did not reach idle");
    chk_busy_hold: assert property (cnt != '0 && !(go_act || go_rd || go_wr || go_pre)
        |=> $stable(state))
        else $error("state left before counter expiry");
    cov_read_ap: cover property (go_rd && auto_pre);
    cov_wr_then_rd: cover property (state == ddr2_cmd_pkg::BANK_WRITING && go_rd);
endmodule
`default_nettype wire

// ===== hw/ddr2_bank_command_state.sv
// DDR2 command decode, legality and bank/device state tracking
//
// Function
// - Deselect and no-op continue current operation
// - Activate to idle bank opens row
// - Row active: read or write starts burst
// - Row active: precharge closes addressed row
// - During read: read, write, precharge accepted
// - During write: read, write, precharge accepted
// - Commands count only with clock enable steady high
// - Idle after precharge period and burst end
// - Row active after activate-to-column delay
// - Read state lasts until burst ends
// - Write state lasts until burst ends
// - Precharge state ends idle after tRP
// - Read with auto precharge busy until idle
// - Activate state ends row active after tRCD
// - Write with auto precharge busy until idle
// - Refresh ends with all banks idle
// - Mode load ends with all banks idle
// - Precharge all ends with banks idle
`timescale 1ns/1ps
`default_nettype none
module ddr2_bank_command_state #(
    parameter int NUM_BANKS = ddr2_cmd_pkg::NUM_BANKS,
    parameter int BANK_W    = ddr2_cmd_pkg::BANK_W,
    parameter int CNT_W     = ddr2_cmd_pkg::CNT_W,
    parameter int TRCD_CYC  = ddr2_cmd_pkg::TRCD_CYC,
    parameter int TRP_CYC   = ddr2_cmd_pkg::TRP_CYC,
    parameter int TRFC_CYC  = ddr2_cmd_pkg::TRFC_CYC,
    parameter int TMRD_CYC  = ddr2_cmd_pkg::TMRD_CYC,
    parameter int TXSNR_CYC = ddr2_cmd_pkg::TXSNR_CYC,
    parameter int BURST_CYC = ddr2_cmd_pkg::BURST_CYC
) (
    input  wire logic                   CORE_CLK,
    input  wire logic                   RESET_N,
    input  wire logic                   CKE,
    input  wire logic                   CS_N,
    input  wire logic                   RAS_N,
    input  wire logic                   CAS_N,
    input  wire logic                   WE_N,
    input  wire logic [BANK_W-1:0]      BA,
    input  wire logic                   A10,
    output logic [3*NUM_BANKS-1:0]      BANK_STATE,
    output ddr2_cmd_pkg::dev_state_t    DEV_STATE,
    output logic                        ALL_IDLE,
    output logic                        CMD_ACCEPT,
    output logic                        CMD_REJECT
);
    localparam int PIN_W = BANK_W + 6;   // Sampled pin bundle

    logic                      rst_meta;      // Reset release stage 1
    logic                      rst_sync;      // Reset used by the design
    logic [PIN_W-1:0]          pin_meta;      // Pin stage 1
    logic [PIN_W-1:0]          pin_sync;      // Pin stage 2
    logic                      cke_prev;      // Clock enable last cycle
    logic                      sr_active;     // In self refresh
    logic                      next_sr_active;
    logic [CNT_W-1:0]          xsnr_cnt;      // Self-refresh exit wait
    logic [CNT_W-1:0]          next_xsnr_cnt;
    ddr2_cmd_pkg::dev_state_t  dev_state;     // Device-wide state
    ddr2_cmd_pkg::dev_state_t  next_dev_state;
    logic [CNT_W-1:0]          dev_cnt;       // Device-wide timer
    logic [CNT_W-1:0]          next_dev_cnt;
    logic                      next_accept;
    logic                      next_reject;
    logic                      next_all_idle;
    ddr2_cmd_pkg::bank_state_t bank_state [NUM_BANKS];
    ddr2_cmd_pkg::cmd_t        cmd;           // Current decoded command
    logic                      cke;           // Synced clock enable
    logic [BANK_W-1:0]         ba;            // Synced bank address
    logic                      a10;           // Synced auto/all bit
    logic                      cmd_en;        // Command window open
    logic                      banks_idle;    // Every bank idle
    logic                      pall_ok;       // All banks may precharge
    logic [NUM_BANKS-1:0]      go_act;
    logic [NUM_BANKS-1:0]      go_rd;
    logic [NUM_BANKS-1:0]      go_wr;
    logic [NUM_BANKS-1:0]      go_pre;

    // Decode the four strobes plus A10 into a command
    function automatic ddr2_cmd_pkg::cmd_t decode_cmd(
        input logic [4:0] pins
    );
        // Order: cs_n, ras_n, cas_n, we_n, a10
        unique casez (pins)
            5'b1????: decode_cmd = ddr2_cmd_pkg::CMD_DESEL;
            5'b0111?: decode_cmd = ddr2_cmd_pkg::CMD_NOP;
            5'b0011?: decode_cmd = ddr2_cmd_pkg::CMD_ACT;
            5'b0101?: decode_cmd = ddr2_cmd_pkg::CMD_RD;
            5'b0100?: decode_cmd = ddr2_cmd_pkg::CMD_WR;
            5'b00100: decode_cmd = ddr2_cmd_pkg::CMD_PRE;
            5'b00101: decode_cmd = ddr2_cmd_pkg::CMD_PALL;
            5'b0001?: decode_cmd = ddr2_cmd_pkg::CMD_REF;
            5'b0000?: decode_cmd = ddr2_cmd_pkg::CMD_MRS;
            default:  decode_cmd = ddr2_cmd_pkg::CMD_NOP;
        endcase
    endfunction

    // Bank may take a column access or a precharge
    function automatic logic open_row(
        input ddr2_cmd_pkg::bank_state_t s
    );
        open_row = (s == ddr2_cmd_pkg::BANK_ROW_ACTIVE)
                || (s == ddr2_cmd_pkg::BANK_READING)
                || (s == ddr2_cmd_pkg::BANK_WRITING);
    endfunction

    // Reset: asserts at once, releases after two edges
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Pins come from the controller's pads: two stages
    always_ff @(posedge CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            cke_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= {CKE, CS_N, RAS_N, CAS_N, WE_N, A10, BA};
            pin_sync <= pin_meta;
            cke_prev <= pin_sync[PIN_W-1];
        end
    end

    assign cke = pin_sync[PIN_W-1];
    assign a10 = pin_sync[BANK_W];
    assign ba  = pin_sync[BANK_W-1:0];
    assign cmd = decode_cmd(pin_sync[BANK_W+4:BANK_W]);

    // Self refresh entry and exit wait
    always_comb
    begin
        next_sr_active = sr_active;
        next_xsnr_cnt  = (xsnr_cnt != '0) ? xsnr_cnt - CNT_W'(1) : xsnr_cnt;
        if (cke_prev && !cke && cmd == ddr2_cmd_pkg::CMD_REF)
        begin
            // Refresh with clock enable falling
            next_sr_active = 1'b1;
        end
        else if (sr_active && cke && !cke_prev)
        begin
            // Exit: hold off commands for tXSNR
            next_sr_active = 1'b0;
            next_xsnr_cnt  = CNT_W'(TXSNR_CYC);
        end
    end

    // Self refresh registers
    always_ff @(posedge CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            sr_active <= 1'b0;
            xsnr_cnt  <= '0;
        end
        else
        begin
            sr_active <= next_sr_active;
            xsnr_cnt  <= next_xsnr_cnt;
        end
    end

    // Commands count only with clock enable high twice
    assign cmd_en = cke_prev && cke && !sr_active && xsnr_cnt == '0;

    // Bank summaries
    always_comb
    begin
        banks_idle = 1'b1;
        pall_ok    = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            banks_idle = banks_idle && bank_state[b] == ddr2_cmd_pkg::BANK_IDLE;
            // Idle banks may be precharged again
            pall_ok = pall_ok && (open_row(bank_state[b])
                      || bank_state[b] == ddr2_cmd_pkg::BANK_IDLE);
        end
    end

    // Legality check and bank strobes; illegal commands are dropped
    always_comb
    begin
        next_accept = 1'b0;
        next_reject = 1'b0;
        go_act      = '0;
        go_rd       = '0;
        go_wr       = '0;
        go_pre      = '0;
        // Deselect and no-op fall through untouched
        if (cmd_en && cmd != ddr2_cmd_pkg::CMD_DESEL && cmd != ddr2_cmd_pkg::CMD_NOP)
        begin
            if (dev_state != ddr2_cmd_pkg::DEV_NORMAL)
            begin
                // Device-wide busy: nothing executes
                next_reject = 1'b1;
            end
            else
            begin
                unique case (cmd)
                    ddr2_cmd_pkg::CMD_REF,
                    ddr2_cmd_pkg::CMD_MRS:
                    begin
                        // Whole device must be idle
                        next_accept = banks_idle;
                        next_reject = !banks_idle;
                    end
                    ddr2_cmd_pkg::CMD_PALL:
                    begin
                        next_accept = pall_ok;
                        next_reject = !pall_ok;
                        go_pre      = pall_ok ? '1 : '0;
                    end
                    ddr2_cmd_pkg::CMD_ACT:
                    begin
                        // Only an idle bank opens a row
                        next_accept = bank_state[ba] == ddr2_cmd_pkg::BANK_IDLE;
                        next_reject = !next_accept;
                        go_act[ba]  = next_accept;
                    end
                    ddr2_cmd_pkg::CMD_RD,
                    ddr2_cmd_pkg::CMD_WR,
                    ddr2_cmd_pkg::CMD_PRE:
                    begin
                        // Open row, even mid-burst
                        next_accept = open_row(bank_state[ba]);
                        next_reject = !next_accept;
                        go_rd[ba]   = next_accept && cmd == ddr2_cmd_pkg::CMD_RD;
                        go_wr[ba]   = next_accept && cmd == ddr2_cmd_pkg::CMD_WR;
                        go_pre[ba]  = next_accept && cmd == ddr2_cmd_pkg::CMD_PRE;
                    end
                    ddr2_cmd_pkg::CMD_DESEL,
                    ddr2_cmd_pkg::CMD_NOP:
                    begin
                        next_accept = 1'b0;
                    end
                endcase
            end
        end
    end

    // Device-wide state and timer
    always_comb
    begin
        next_dev_state = dev_state;
        next_dev_cnt   = (dev_cnt != '0) ? dev_cnt - CNT_W'(1) : dev_cnt;
        next_all_idle  = banks_idle && dev_state == ddr2_cmd_pkg::DEV_NORMAL;
        if (next_accept && cmd == ddr2_cmd_pkg::CMD_REF)
        begin
            next_dev_state = ddr2_cmd_pkg::DEV_REFRESH;
            next_dev_cnt   = CNT_W'(TRFC_CYC - 1);
        end
        else if (next_accept && cmd == ddr2_cmd_pkg::CMD_MRS)
        begin
            next_dev_state = ddr2_cmd_pkg::DEV_MODE;
            next_dev_cnt   = CNT_W'(TMRD_CYC - 1);
        end
        else if (next_accept && cmd == ddr2_cmd_pkg::CMD_PALL)
        begin
            // Banks run the same tRP timer alongside
            next_dev_state = ddr2_cmd_pkg::DEV_PALL;
            next_dev_cnt   = CNT_W'(TRP_CYC - 1);
        end
        else if (dev_state != ddr2_cmd_pkg::DEV_NORMAL && dev_cnt == '0)
        begin
            // Delay met: back to all banks idle
            next_dev_state = ddr2_cmd_pkg::DEV_NORMAL;
        end
    end

    // Device registers and status outputs
    always_ff @(posedge CORE_CLK or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            dev_state  <= ddr2_cmd_pkg::DEV_NORMAL;
            dev_cnt    <= '0;
            CMD_ACCEPT <= 1'b0;
            CMD_REJECT <= 1'b0;
            ALL_IDLE   <= 1'b0;
        end
        else
        begin
            dev_state  <= next_dev_state;
            dev_cnt    <= next_dev_cnt;
            CMD_ACCEPT <= next_accept;
            CMD_REJECT <= next_reject;
            ALL_IDLE   <= next_all_idle;
        end
    end

    assign DEV_STATE = dev_state;

    // One tracker per bank
    for (genvar g = 0; g < NUM_BANKS; g++)
    begin : g_bank
        bank_state_tracker #(
            .TRCD_CYC  (TRCD_CYC),
            .TRP_CYC   (TRP_CYC),
            .BURST_CYC (BURST_CYC),
            .CNT_W     (CNT_W)
        ) u_bank (
            .clk      (CORE_CLK),
            .rst_n    (rst_sync),
            .go_act   (go_act[g]),
            .go_rd    (go_rd[g]),
            .go_wr    (go_wr[g]),
            .go_pre   (go_pre[g]),
            .auto_pre (a10),
            .state    (bank_state[g])
        );
        assign BANK_STATE[3*g +: 3] = bank_state[g];
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!rst_sync);

    chk_nop_quiet: assert property (!cmd_en || cmd == ddr2_cmd_pkg::CMD_NOP
        || cmd == ddr2_cmd_pkg::CMD_DESEL |=> !CMD_ACCEPT && !CMD_REJECT)
        else $error("no-op produced a verdict");
    chk_cke_gate: assert property (!(cke_prev && cke) |-> go_act == '0 && go_pre == '0)
        else $error("command taken without clock enable");
    chk_ref_enter: assert property (next_accept && cmd == ddr2_cmd_pkg::CMD_REF
        |=> DEV_STATE == ddr2_cmd_pkg::DEV_REFRESH ##(TRFC_CYC) DEV_STATE == ddr2_cmd_pkg::DEV_NORMAL)
        else $error("refresh timing wrong");
    chk_dev_idle: assert property (dev_state != ddr2_cmd_pkg::DEV_NORMAL && dev_cnt == '0
        |=> dev_state == ddr2_cmd_pkg::DEV_NORMAL ##1 ALL_IDLE)
        else $error("device not idle after busy state");
    chk_busy_reject: assert property (cmd_en && dev_state != ddr2_cmd_pkg::DEV_NORMAL
        && cmd == ddr2_cmd_pkg::CMD_ACT |=> CMD_REJECT)
        else $error("command during busy device accepted");
    cov_refresh: cover property (next_accept && cmd == ddr2_cmd_pkg::CMD_REF);
    cov_pall: cover property (next_accept && cmd == ddr2_cmd_pkg::CMD_PALL);
    cov_reject: cover property (CMD_REJECT);
endmodule
`default_nettype wire

// ===== tb/ddr2_ctrl_model.sv
// Behavioural memory controller that encodes commands onto the strobes
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctrl_model (
    input  wire logic               clk,
    input  wire ddr2_cmd_pkg::cmd_t cmd,
    output logic [3:0]              pins
);
    logic flip = 1'b0; // Deselected strobes wander so no stale value is trusted
    // Free-running toggle
    always @(posedge clk) flip <= ~flip;
    // Strobe order is cs_n, ras_n, cas_n, we_n
    always_comb
    begin
        case (cmd)
            ddr2_cmd_pkg::CMD_DESEL: pins = {1'b1, flip, ~flip, flip};
            ddr2_cmd_pkg::CMD_ACT:   pins = 4'h3;
            ddr2_cmd_pkg::CMD_RD:    pins = 4'h5;
            ddr2_cmd_pkg::CMD_WR:    pins = 4'h4;
            ddr2_cmd_pkg::CMD_PRE,
            ddr2_cmd_pkg::CMD_PALL:  pins = 4'h2;
            ddr2_cmd_pkg::CMD_REF:   pins = 4'h1;
            ddr2_cmd_pkg::CMD_MRS:   pins = 4'h0;
            default:                 pins = 4'h7;
        endcase
    end
endmodule
`default_nettype wire

// ===== tb/ddr2_bank_command_state_tb.sv
// Self-checking bench for the DDR2 bank command tracker
`timescale 1ns/1ps
`default_nettype none
module ddr2_bank_command_state_tb;
    localparam int RCD = 2; // Short delays keep the run brief
    localparam int RP  = 2;
    localparam int RFC = 6; // Long enough to inject a command mid-refresh
    localparam int MRD = 2;
    localparam int BUR = 2;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     cke = 1'b0;
    logic [1:0]               ba = 2'h0;
    logic                     ap = 1'b0;
    ddr2_cmd_pkg::cmd_t       cmd = ddr2_cmd_pkg::CMD_NOP;
    logic [3:0]               pins;
    logic [11:0]              bank_state;
    ddr2_cmd_pkg::dev_state_t dev_state;
    logic                     all_idle;
    logic                     accept;
    logic                     reject;
    int                       num_errors = 0;
    int                       compares = 0;
    ddr2_ctrl_model u_ctrl (.clk(clk), .cmd(cmd), .pins(pins));
    ddr2_bank_command_state #(.TRCD_CYC(RCD), .TRP_CYC(RP), .TRFC_CYC(RFC), .TMRD_CYC(MRD),
        .TXSNR_CYC(3), .BURST_CYC(BUR)) u_dut (.CORE_CLK(clk), .RESET_N(rst_n), .CKE(cke),
        .CS_N(pins[3]), .RAS_N(pins[2]), .CAS_N(pins[1]), .WE_N(pins[0]), .BA(ba), .A10(ap),
        .BANK_STATE(bank_state), .DEV_STATE(dev_state), .ALL_IDLE(all_idle),
        .CMD_ACCEPT(accept), .CMD_REJECT(reject));
    // 125 MHz clock
    initial forever #4 clk = ~clk;
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One command for one cycle, launched at a rising edge
    task automatic send(input ddr2_cmd_pkg::cmd_t c, input logic [1:0] b, input logic a);
        @(posedge clk);
        cmd <= c;
        ba  <= b;
        ap  <= a;
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Command, then idle until its answer stands, two edges after the pins are sampled
    task automatic go(input ddr2_cmd_pkg::cmd_t c, input logic [1:0] b, input logic a);
        send(c, b, a);
        send(ddr2_cmd_pkg::CMD_NOP, 2'h0, 1'b0);
        hold(2);
    endtask
    function automatic logic [11:0] st(input int b);
        return 12'(bank_state[3*b +: 3]);
    endfunction
    // Open a row, then a second activate must bounce
    task automatic s_open(input logic [1:0] b);
        go(ddr2_cmd_pkg::CMD_ACT, b, 1'b0);
        cmp(12'({accept, reject}), 12'h2);
        cmp(st(b), 12'h1);
        hold(RCD);
        cmp(st(b), 12'h2);
        go(ddr2_cmd_pkg::CMD_ACT, b, 1'b0);
        cmp(12'({accept, reject}), 12'h1);
    endtask
    // Back-to-back column commands restart the burst state each cycle
    task automatic s_burst;
        send(ddr2_cmd_pkg::CMD_RD, 2'h1, 1'b0);
        send(ddr2_cmd_pkg::CMD_WR, 2'h1, 1'b0);
        send(ddr2_cmd_pkg::CMD_RD, 2'h1, 1'b0);
        send(ddr2_cmd_pkg::CMD_PRE, 2'h1, 1'b0);
        hold(0);
        cmp(st(1), 12'h3);
        send(ddr2_cmd_pkg::CMD_NOP, 2'h0, 1'b0);
        hold(0);
        cmp(st(1), 12'h4);
        hold(1);
        cmp(st(1), 12'h3);
        hold(1);
        cmp(st(1), 12'h7);
        hold(RP);
        cmp(st(1), 12'h0);
    endtask
    // Auto-precharge read then write: busy for burst plus precharge
    task automatic s_auto;
        for (int i = 0; i < 2; i++)
        begin
            s_open(2'h2);
            go(i ? ddr2_cmd_pkg::CMD_WR : ddr2_cmd_pkg::CMD_RD, 2'h2, 1'b1);
            cmp(st(2), 12'(5 + i));
            hold(BUR + RP - 1);
            cmp(st(2), 12'(5 + i));
            hold(1);
            cmp(st(2), 12'h0);
        end
    endtask
    // Idle-bank read bounces; deselect, clock-enable-low and self-refresh-exit commands are silent
    task automatic s_quiet;
        go(ddr2_cmd_pkg::CMD_RD, 2'h3, 1'b0);
        cmp(12'({accept, reject}), 12'h1);
        go(ddr2_cmd_pkg::CMD_DESEL, 2'h3, 1'b0);
        cmp(12'({accept, reject}), 12'h0);
        // Refresh with clock enable falling enters self refresh
        send(ddr2_cmd_pkg::CMD_REF, 2'h3, 1'b0);
        cke <= 1'b0;
        go(ddr2_cmd_pkg::CMD_ACT, 2'h3, 1'b0);
        cmp(12'({accept, reject, bank_state[11:9]}), 12'h0);
        @(posedge clk) cke <= 1'b1;
        // Activate inside the exit wait must be ignored as well
        go(ddr2_cmd_pkg::CMD_ACT, 2'h3, 1'b0);
        cmp(12'({accept, reject, bank_state[11:9]}), 12'h0);
    endtask
    // Refresh, mode load and precharge-all, each timed back to all idle
    task automatic s_dev;
        ddr2_cmd_pkg::cmd_t c[3] = '{ddr2_cmd_pkg::CMD_REF, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::CMD_PALL};
        int d[3] = '{RFC, MRD, RP};
        for (int i = 0; i < 3; i++)
        begin
            if (i == 2)
                s_open(2'h0);
            go(c[i], 2'h0, i == 2);
            cmp({accept, reject, 8'h0, dev_state}, 12'h801 + 12'(i));
            cmp(bank_state, i == 2 ? 12'hFFF : 12'h0);
            if (i == 0)
            begin
                send(ddr2_cmd_pkg::CMD_ACT, 2'h0, 1'b0);
                send(ddr2_cmd_pkg::CMD_NOP, 2'h0, 1'b0);
                hold(2);
                cmp(12'({accept, reject}), 12'h1);
                hold(d[i] - 4);
            end
            else
                hold(d[i]);
            cmp({dev_state, bank_state[9:0]}, 12'h0);
            hold(1);
            cmp(12'(all_idle), 12'h1);
        end
    endtask
    // Main sequence: reset for 20 cycles, clock enable high from release
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cke   <= 1'b1;
        hold(6);
        s_open(2'h1);
        s_burst;
        s_auto;
        s_quiet;
        s_dev;
        print_verdict;
    end
    // Watchdog well beyond the fewer than 150 cycles the tests need
    initial
    begin
        #16000;
        num_errors++;
        print_verdict;
    end
endmodule
`default_nettype wire
